// ---- src/pfb_pkg.sv ----
// Shared constants and types of the dual FIFO processor buffer.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package pfb_pkg;

  // ----------------------------------------
  // Buffer geometry
  // ----------------------------------------
  localparam int PFB_DEPTH = 256;
  localparam logic [8:0] PFB_FULL = 9'h100;
  localparam logic [7:0] PFB_PTR_ONE = 8'h01;

  // ----------------------------------------
  // Status word layout
  // ----------------------------------------
  localparam int PFB_SEL_MSB = 15;
  localparam int PFB_SEL_LSB = 13;
  localparam int PFB_WR_ALL_BIT = 12;
  localparam logic [2:0] PFB_SEL_RESET = 3'h0;
  localparam logic [2:0] PFB_SEL_OCNT = 3'h0;
  localparam logic [2:0] PFB_SEL_ICNT = 3'h1;
  localparam logic [2:0] PFB_SEL_FLAGS = 3'h2;
  localparam logic [2:0] PFB_SEL_CTL3 = 3'h3;
  localparam logic [2:0] PFB_SEL_CTL4 = 3'h4;
  localparam logic [2:0] PFB_SEL_CTL5 = 3'h5;
  localparam logic [11:0] PFB_CTL_RESET = 12'h000;
  localparam logic [11:0] PFB_WMASK3 = 12'h0FF;
  localparam logic [11:0] PFB_WMASK4 = 12'h0FF;
  localparam logic [11:0] PFB_WMASK5 = 12'h007;
  localparam int PFB_LAB_BIT = 0;
  localparam int PFB_LAA_BIT = 1;
  localparam int PFB_RR_BIT = 2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] par;
    logic [15:0] data;
  } pfb_half_t;

  typedef struct packed {
    pfb_half_t hi;
    pfb_half_t lo;
  } pfb_entry_t;

  typedef struct packed {
    logic dp;
    logic dr;
    logic cp;
    logic sense_status_read;
  } pfb_cmd_t;

  typedef struct packed {
    logic [17:0] addr;
    logic addr_par;
    logic [31:0] data;
    logic [3:0] dpar;
    logic ovr_par;
  } pfb_sw_word_t;

  typedef enum logic {PS_IDLE, PS_DONE} pfb_pstate_t;

endpackage : pfb_pkg

// ---- src/pfb_dual_fifo_buffer.sv ----
// Processor-side controller with both FIFO buffers and the switch-side port.
// Assumes processor command pins are asynchronous; switch side shares the clock.
//
// Function
// - Holding registers are 18 bits: 16 data plus one parity per byte.
// - Memory bus is 36 bits; low write register fills the low half.
// - Pointer low: data write loads low register, toggles pointer; next loads high.
// - After second data write, both halves stored as one entry; pointer back low.
// - Pointer low: data read returns low register, copies to low echo, toggles.
// - Second data read returns high register, copies to high echo, refills, pointer low.
// - Six 16-bit status registers; only fourth to sixth writable, in some bits.
// - Top three bits select status register 000 to 101 for next access.
// - Command write with bit 12 clear updates selector only; set writes register.
// - Sense status returns the register picked by the selector.
// - Processor-side loop bit moves inbound entries into the outbound buffer.
// - Switch-side loop bit moves outbound entries into the inbound buffer.
// - Switch short loop: written data goes straight to output register.
// - Processor loop or reread: writes fill echo registers, reads return them.
// - Switch deep loop chains write, inbound-to-outbound move and read.
// - Processor deep loop: stored word moves at once to inbound buffer.
// - All held data carries odd parity per byte, passed through unchanged.
// - Words to switch carry odd parity over 18 address and 23 data bits.
// - Bad switch address or overall parity: nothing stored, no acknowledge.
// - Bad processor write parity blocks the entry from the outbound buffer.
`timescale 1ns/10ps
module pfb_dual_fifo_buffer (
  input wire logic clock,
  input wire logic sys_rst,
  input wire pfb_pkg::pfb_cmd_t proc_cmd,
  input wire pfb_pkg::pfb_half_t proc_wdata,
  output logic proc_sync,
  output logic proc_error,
  output pfb_pkg::pfb_half_t proc_rdata,
  input wire logic sw_wr_req,
  input wire pfb_pkg::pfb_sw_word_t sw_wr,
  output logic sw_wr_ack,
  input wire logic sw_rd_req,
  input wire logic [17:0] sw_rd_addr,
  output logic [22:0] sw_rd_data,
  output logic sw_rd_par
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  pfb_pkg::pfb_cmd_t cmd_s1_q, cmd_s2_q;
  pfb_pkg::pfb_half_t wd_s1_q, wd_s2_q;
  pfb_pkg::pfb_pstate_t pstate_q, pstate_d;
  logic wptr_q, wptr_d, rptr_q, rptr_d, rvalid_q, rvalid_d, werr_q, werr_d;
  logic err_proc_q, err_proc_d, err_sw_q, err_sw_d, swvalid_q, swvalid_d;
  logic ack_q, ack_d, swpar_q, swpar_d;
  pfb_pkg::pfb_half_t jreg_q, jreg_d, kreg_q, kreg_d, nreg_q, nreg_d, oreg_q, oreg_d;
  pfb_pkg::pfb_half_t lreg_q, lreg_d, mreg_q, mreg_d, rdata_q, rdata_d;
  logic [2:0] sel_q, sel_d;
  logic [11:0] ctl3_q, ctl3_d, ctl4_q, ctl4_d, ctl5_q, ctl5_d;
  pfb_pkg::pfb_entry_t obuf [pfb_pkg::PFB_DEPTH];
  pfb_pkg::pfb_entry_t ibuf [pfb_pkg::PFB_DEPTH];
  pfb_pkg::pfb_entry_t ob_wdata, ib_wdata, ob_head, ib_head, swmem_q, swmem_d;
  logic [7:0] o_wp_q, o_wp_d, o_rp_q, o_rp_d, i_wp_q, i_wp_d, i_rp_q, i_rp_d;
  logic [8:0] o_cnt_q, o_cnt_d, i_cnt_q, i_cnt_d;
  logic [22:0] swout_q, swout_d;
  logic ob_we, ib_we, ob_pop, ib_pop, proc_store, sw_push, sw_ok, par_ok;
  logic go, go_dp, go_dr, go_cp, go_sst, loop_from_processor_side, loop_from_switch_side, echo_mode, o_full, i_full;
  logic [15:0] stat_word;

  function automatic logic [1:0] odd_par(input logic [15:0] d);
    return {~^d[15:8], ~^d[7:0]};
  endfunction : odd_par

  function automatic logic [22:0] shorten(input logic [31:0] d);
    return {d[22:14] & d[31:23], d[13:0]};
  endfunction : shorten

  assign ob_head = obuf[o_rp_q];
  assign ib_head = ibuf[i_rp_q];
  assign loop_from_processor_side = ctl5_q[pfb_pkg::PFB_LAB_BIT];
  assign loop_from_switch_side = ctl5_q[pfb_pkg::PFB_LAA_BIT];
  assign echo_mode = loop_from_processor_side | ctl5_q[pfb_pkg::PFB_RR_BIT];
  assign o_full = (o_cnt_q == pfb_pkg::PFB_FULL);
  assign i_full = (i_cnt_q == pfb_pkg::PFB_FULL);
  assign par_ok = (^{wd_s2_q.data[7:0], wd_s2_q.par[0]}) & (^{wd_s2_q.data[15:8], wd_s2_q.par[1]});
  assign sw_ok = (^{sw_wr.addr, sw_wr.addr_par}) & (^{sw_wr.addr, sw_wr.data[22:0], sw_wr.ovr_par});
  assign proc_sync = (pstate_q == pfb_pkg::PS_DONE);
  assign proc_error = err_proc_q | err_sw_q;
  assign proc_rdata = rdata_q;
  assign sw_wr_ack = ack_q;
  assign sw_rd_data = swout_q;
  assign sw_rd_par = swpar_q;

  // ----------------------------------------
  // Status word mux
  // ----------------------------------------
  always_comb begin
    case (sel_q)
      pfb_pkg::PFB_SEL_OCNT: stat_word = {sel_q, 4'h0, o_cnt_q};
      pfb_pkg::PFB_SEL_ICNT: stat_word = {sel_q, 4'h0, i_cnt_q};
      pfb_pkg::PFB_SEL_FLAGS: stat_word = {sel_q, 6'h00, rvalid_q, rptr_q, wptr_q, (i_cnt_q == 9'h000), o_full,
                                           err_sw_q, err_proc_q};
      pfb_pkg::PFB_SEL_CTL3: stat_word = {sel_q, 1'b0, ctl3_q};
      pfb_pkg::PFB_SEL_CTL4: stat_word = {sel_q, 1'b0, ctl4_q};
      pfb_pkg::PFB_SEL_CTL5: stat_word = {sel_q, 1'b0, ctl5_q};
      default: stat_word = {sel_q, 13'h0000};
    endcase
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    pstate_d = pstate_q;
    wptr_d = wptr_q;
    rptr_d = rptr_q;
    rvalid_d = rvalid_q;
    werr_d = werr_q;
    err_proc_d = err_proc_q;
    err_sw_d = err_sw_q;
    jreg_d = jreg_q;
    kreg_d = kreg_q;
    nreg_d = nreg_q;
    oreg_d = oreg_q;
    lreg_d = lreg_q;
    mreg_d = mreg_q;
    rdata_d = rdata_q;
    sel_d = sel_q;
    ctl3_d = ctl3_q;
    ctl4_d = ctl4_q;
    ctl5_d = ctl5_q;
    swmem_d = swmem_q;
    swvalid_d = swvalid_q;
    swout_d = swout_q;
    swpar_d = swpar_q;
    ack_d = 1'b0;
    ob_we = 1'b0;
    ib_we = 1'b0;
    ob_pop = 1'b0;
    ib_pop = 1'b0;
    ob_wdata = {wd_s2_q, jreg_q};
    ib_wdata = {sw_wr.dpar[3:2], sw_wr.data[31:16], sw_wr.dpar[1:0], sw_wr.data[15:0]};
    proc_store = 1'b0;
    sw_push = 1'b0;
    go_dp = 1'b0;
    go_dr = 1'b0;
    go_cp = 1'b0;
    go_sst = 1'b0;
    // Command handshake: stall holds sync low until the order can complete
    go = (pstate_q == pfb_pkg::PS_IDLE) && (cmd_s2_q != 4'h0);
    if (go && cmd_s2_q.dp && !echo_mode && wptr_q && o_full) go = 1'b0;
    if (go && cmd_s2_q.dr && !echo_mode && !rptr_q && !rvalid_q) go = 1'b0;
    if (pstate_q == pfb_pkg::PS_DONE && cmd_s2_q == 4'h0) pstate_d = pfb_pkg::PS_IDLE;
    if (go) begin
      pstate_d = pfb_pkg::PS_DONE;
      if (cmd_s2_q.dp) begin
        go_dp = 1'b1;
        wptr_d = !wptr_q;
        if (echo_mode) begin
          if (!wptr_q) lreg_d = wd_s2_q;
          else mreg_d = wd_s2_q;
        end else if (!wptr_q) begin
          jreg_d = wd_s2_q;
          werr_d = !par_ok;
          if (!par_ok) err_proc_d = 1'b1;
        end else begin
          kreg_d = wd_s2_q;
          if (par_ok && !werr_q) begin
            proc_store = 1'b1;
            ob_we = 1'b1;
          end else begin
            err_proc_d = 1'b1;
          end
        end
      end else if (cmd_s2_q.dr) begin
        go_dr = 1'b1;
        rptr_d = !rptr_q;
        if (echo_mode) begin
          rdata_d = rptr_q ? mreg_q : lreg_q;
        end else if (!rptr_q) begin
          rdata_d = nreg_q;
          lreg_d = nreg_q;
        end else begin
          rdata_d = oreg_q;
          mreg_d = oreg_q;
          rvalid_d = 1'b0;
        end
      end else if (cmd_s2_q.cp) begin
        go_cp = 1'b1;
        sel_d = wd_s2_q.data[pfb_pkg::PFB_SEL_MSB:pfb_pkg::PFB_SEL_LSB];
        if (wd_s2_q.data[pfb_pkg::PFB_WR_ALL_BIT]) begin
          case (sel_q)
            pfb_pkg::PFB_SEL_CTL3: ctl3_d = (ctl3_q & ~pfb_pkg::PFB_WMASK3) | (wd_s2_q.data[11:0] & pfb_pkg::PFB_WMASK3);
            pfb_pkg::PFB_SEL_CTL4: ctl4_d = (ctl4_q & ~pfb_pkg::PFB_WMASK4) | (wd_s2_q.data[11:0] & pfb_pkg::PFB_WMASK4);
            pfb_pkg::PFB_SEL_CTL5: ctl5_d = (ctl5_q & ~pfb_pkg::PFB_WMASK5) | (wd_s2_q.data[11:0] & pfb_pkg::PFB_WMASK5);
            default: ;
          endcase
        end
      end else begin
        go_sst = 1'b1;
        rdata_d = {odd_par(stat_word), stat_word};
        if (sel_q == pfb_pkg::PFB_SEL_FLAGS) begin
          err_proc_d = 1'b0;
          err_sw_d = 1'b0;
        end
      end
    end
    // Switch-side write, checked before anything is stored
    if (sw_wr_req) begin
      if (!sw_ok) begin
        err_sw_d = 1'b1;
      end else if (loop_from_switch_side) begin
        swout_d = shorten(sw_wr.data);
        ack_d = 1'b1;
      end else if (!i_full) begin
        sw_push = 1'b1;
        ib_we = 1'b1;
        ack_d = 1'b1;
      end
    end
    // Switch-side read with fresh overall parity
    if (sw_rd_req) begin
      if (!loop_from_switch_side) begin
        swout_d = shorten({swmem_q.hi.data, swmem_q.lo.data});
        swvalid_d = 1'b0;
      end
      swpar_d = ~^{sw_rd_addr, swout_d};
    end
    // Refill the read registers from the inbound buffer
    if (!rvalid_d && i_cnt_q != 9'h000) begin
      nreg_d = ib_head.lo;
      oreg_d = ib_head.hi;
      rvalid_d = 1'b1;
      ib_pop = 1'b1;
    end
    // Refill the memory register, skipped in short loop
    if (!loop_from_switch_side && !swvalid_d && o_cnt_q != 9'h000) begin
      swmem_d = ob_head;
      swvalid_d = 1'b1;
      ob_pop = 1'b1;
    end
    // Inbound to outbound move while the processor loop bit is set
    if (loop_from_processor_side && !ib_pop && !ob_we && !o_full && i_cnt_q != 9'h000) begin
      ob_wdata = ib_head;
      ob_we = 1'b1;
      ib_pop = 1'b1;
    end
    // Outbound to inbound move while the switch loop bit is set
    if (loop_from_switch_side && !ob_pop && !ib_we && !i_full && o_cnt_q != 9'h000) begin
      ib_wdata = ob_head;
      ib_we = 1'b1;
      ob_pop = 1'b1;
    end
    if (proc_store) wptr_d = 1'b0;
    if (go_dr && !echo_mode && rptr_q) rptr_d = 1'b0;
    o_wp_d = ob_we ? o_wp_q + pfb_pkg::PFB_PTR_ONE : o_wp_q;
    o_rp_d = ob_pop ? o_rp_q + pfb_pkg::PFB_PTR_ONE : o_rp_q;
    i_wp_d = ib_we ? i_wp_q + pfb_pkg::PFB_PTR_ONE : i_wp_q;
    i_rp_d = ib_pop ? i_rp_q + pfb_pkg::PFB_PTR_ONE : i_rp_q;
    o_cnt_d = o_cnt_q + {8'h00, ob_we} - {8'h00, ob_pop};
    i_cnt_d = i_cnt_q + {8'h00, ib_we} - {8'h00, ib_pop};
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    cmd_s1_q <= proc_cmd;
    cmd_s2_q <= cmd_s1_q;
    wd_s1_q <= proc_wdata;
    wd_s2_q <= wd_s1_q;
    if (ob_we) obuf[o_wp_q] <= ob_wdata;
    if (ib_we) ibuf[i_wp_q] <= ib_wdata;
    if (sys_rst) begin
      pstate_q <= pfb_pkg::PS_IDLE;
      wptr_q <= 1'b0;
      rptr_q <= 1'b0;
      sel_q <= pfb_pkg::PFB_SEL_RESET;
      rvalid_q <= 1'b0;
      werr_q <= 1'b0;
      err_proc_q <= 1'b0;
      err_sw_q <= 1'b0;
      swvalid_q <= 1'b0;
      ack_q <= 1'b0;
      swpar_q <= 1'b0;
      jreg_q <= 18'h00000;
      kreg_q <= 18'h00000;
      nreg_q <= 18'h00000;
      oreg_q <= 18'h00000;
      lreg_q <= 18'h00000;
      mreg_q <= 18'h00000;
      rdata_q <= 18'h00000;
      ctl3_q <= pfb_pkg::PFB_CTL_RESET;
      ctl4_q <= pfb_pkg::PFB_CTL_RESET;
      ctl5_q <= pfb_pkg::PFB_CTL_RESET;
      swmem_q <= 36'h000000000;
      swout_q <= 23'h000000;
      o_wp_q <= 8'h00;
      o_rp_q <= 8'h00;
      i_wp_q <= 8'h00;
      i_rp_q <= 8'h00;
      o_cnt_q <= 9'h000;
      i_cnt_q <= 9'h000;
    end else begin
      pstate_q <= pstate_d;
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      sel_q <= sel_d;
      rvalid_q <= rvalid_d;
      werr_q <= werr_d;
      err_proc_q <= err_proc_d;
      err_sw_q <= err_sw_d;
      swvalid_q <= swvalid_d;
      ack_q <= ack_d;
      swpar_q <= swpar_d;
      jreg_q <= jreg_d;
      kreg_q <= kreg_d;
      nreg_q <= nreg_d;
      oreg_q <= oreg_d;
      lreg_q <= lreg_d;
      mreg_q <= mreg_d;
      rdata_q <= rdata_d;
      ctl3_q <= ctl3_d;
      ctl4_q <= ctl4_d;
      ctl5_q <= ctl5_d;
      swmem_q <= swmem_d;
      swout_q <= swout_d;
      o_wp_q <= o_wp_d;
      o_rp_q <= o_rp_d;
      i_wp_q <= i_wp_d;
      i_rp_q <= i_rp_d;
      o_cnt_q <= o_cnt_d;
      i_cnt_q <= i_cnt_d;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_first_half;
    go_dp && !echo_mode && !wptr_q;
  endsequence

  sequence s_second_half_good;
    go_dp && !echo_mode && wptr_q && par_ok && !werr_q;
  endsequence

  a_low_half_load: assert property (s_first_half |=> wptr_q && jreg_q == $past(wd_s2_q))
    else $error("low write half not loaded");
  a_entry_store: assert property (s_second_half_good |-> ob_we && ob_wdata.lo == jreg_q ##1 !wptr_q)
    else $error("entry not stored after second write");
  a_parity_block: assert property (go_dp && !echo_mode && wptr_q && (!par_ok || werr_q) |-> !proc_store ##1 err_proc_q)
    else $error("bad parity entry not blocked");
  a_read_low: assert property (go_dr && !echo_mode && !rptr_q |=> rptr_q && proc_rdata == $past(nreg_q) && lreg_q == proc_rdata)
    else $error("low read half wrong");
  a_read_high: assert property (go_dr && !echo_mode && rptr_q |=> !rptr_q && proc_rdata == $past(oreg_q) && mreg_q == proc_rdata)
    else $error("high read half wrong");
  a_echo_write: assert property (go_dp && echo_mode && !wptr_q |=> lreg_q == $past(wd_s2_q) && wptr_q)
    else $error("echo register not loaded");
  a_select_update: assert property (go_cp |=> sel_q == $past(wd_s2_q.data[15:13]))
    else $error("selector not updated");
  a_status_read: assert property (go_sst |=> proc_rdata.data[15:13] == $past(sel_q) && proc_sync)
    else $error("status read wrong");
  a_sw_reject: assert property (sw_wr_req && !sw_ok |-> !sw_push ##1 !sw_wr_ack)
    else $error("bad switch word accepted");
  a_sw_accept: assert property (sw_wr_req && sw_ok && !loop_from_switch_side && !i_full |-> sw_push ##1 sw_wr_ack)
    else $error("good switch word not acknowledged");
  a_out_parity: assert property (sw_rd_req |=> ^{$past(sw_rd_addr), sw_rd_data, sw_rd_par})
    else $error("switch word parity not odd");
  a_reset_state: assert property ($past(sys_rst) |-> !wptr_q && !rptr_q && sel_q == 3'h0)
    else $error("reset state wrong");

endmodule : pfb_dual_fifo_buffer

// ---- verif/pfb_proc_model.sv ----
// Auxiliary processor model issuing orders over the command and sync handshake.
// Assumes the bench calls order() and that the block shares its clock.
`timescale 1ns/10ps
module pfb_proc_model (
  input wire logic clock,
  output pfb_pkg::pfb_cmd_t proc_cmd,
  output pfb_pkg::pfb_half_t proc_wdata,
  input wire logic proc_sync,
  input wire pfb_pkg::pfb_half_t proc_rdata
);
  // ----------------------------------------
  // Order handshake
  // ----------------------------------------
  initial begin
    proc_cmd = '0;
    proc_wdata = '0;
  end

  // One order per handshake, one half per data write
  task automatic order(input logic [1:0] kind, input pfb_pkg::pfb_half_t wd,
                       output pfb_pkg::pfb_half_t rd, output logic ok);
    int n;
    @(negedge clock);
    proc_wdata = wd;
    proc_cmd = pfb_pkg::pfb_cmd_t'(4'h8 >> kind);
    n = 0;
    while (proc_sync !== 1'h1 && n < 300) begin
      @(negedge clock);
      n++;
    end
    rd = proc_rdata;
    ok = (n < 300);
    proc_cmd = '0;
    proc_wdata = ~wd;
    n = 0;
    while (proc_sync !== 1'h0 && n < 300) begin
      @(negedge clock);
      n++;
    end
    ok = ok && (n < 300);
  endtask : order
endmodule : pfb_proc_model

// ---- verif/dual_fifo_processor_buffer_bench.sv ----
// Self-checking bench of the dual FIFO processor buffer.
// Assumes the processor model above and a 100 MHz clock.
`timescale 1ns/10ps
module dual_fifo_processor_buffer_bench;
  typedef struct packed {
    logic [1:0] kind;
    logic [15:0] d;
    logic [15:0] e;
    logic chk;
  } pfb_row_t;
  localparam logic [1:0] K_DP = 2'h0;
  localparam logic [1:0] K_DR = 2'h1;
  localparam logic [1:0] K_CP = 2'h2;
  localparam logic [1:0] K_SST = 2'h3;
  logic clock = 1'h0;
  logic sys_rst = 1'h1;
  pfb_pkg::pfb_cmd_t proc_cmd;
  pfb_pkg::pfb_half_t proc_wdata;
  logic proc_sync;
  logic proc_error;
  pfb_pkg::pfb_half_t proc_rdata;
  logic sw_wr_req = 1'h0;
  pfb_pkg::pfb_sw_word_t sw_wr = '0;
  logic sw_wr_ack;
  logic sw_rd_req = 1'h0;
  logic [17:0] sw_rd_addr = 18'h00000;
  logic [22:0] sw_rd_data;
  logic sw_rd_par;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  pfb_row_t rows [20];
  pfb_pkg::pfb_half_t rd;
  logic ok;
  logic ack;
  logic [31:0] wd;
  logic [22:0] e23;

  pfb_dual_fifo_buffer pfb_dual_fifo_buffer_inst (.clock(clock), .sys_rst(sys_rst), .proc_cmd(proc_cmd),
    .proc_wdata(proc_wdata), .proc_sync(proc_sync), .proc_error(proc_error), .proc_rdata(proc_rdata),
    .sw_wr_req(sw_wr_req), .sw_wr(sw_wr), .sw_wr_ack(sw_wr_ack), .sw_rd_req(sw_rd_req),
    .sw_rd_addr(sw_rd_addr), .sw_rd_data(sw_rd_data), .sw_rd_par(sw_rd_par));

  pfb_proc_model pfb_proc_model_inst (.clock(clock), .proc_cmd(proc_cmd), .proc_wdata(proc_wdata),
    .proc_sync(proc_sync), .proc_rdata(proc_rdata));

  // ----------------------------------------
  // Clock and timeout
  // ----------------------------------------
  always #5 clock = ~clock;

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      complete_run();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic pfb_pkg::pfb_half_t mk(input logic [15:0] d);
    mk = {~^d[15:8], ~^d[7:0], d};
  endfunction : mk

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic op(input logic [1:0] k, input pfb_pkg::pfb_half_t h);
    pfb_proc_model_inst.order(k, h, rd, ok);
    check(32'(ok), 32'h1);
  endtask : op

  task automatic sw_write(input logic bad);
    @(negedge clock);
    sw_wr.addr = 18'h00ABC;
    sw_wr.data = wd;
    sw_wr.dpar = {~^wd[31:24], ~^wd[23:16], ~^wd[15:8], ~^wd[7:0]};
    sw_wr.addr_par = (~^sw_wr.addr) ^ bad;
    sw_wr.ovr_par = ~^{sw_wr.addr, wd[22:0]};
    sw_wr_req = 1'h1;
    @(negedge clock);
    sw_wr_req = 1'h0;
    ack = sw_wr_ack;
    @(negedge clock);
    ack = ack | sw_wr_ack;
  endtask : sw_write

  task automatic sw_read();
    @(negedge clock);
    sw_rd_addr = 18'h2D3C5;
    sw_rd_req = 1'h1;
    @(negedge clock);
    sw_rd_req = 1'h0;
    sw_rd_addr = 18'h1A2B3;
    @(negedge clock);
  endtask : sw_read

  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rows = '{'{K_SST, 16'h0000, 16'h0000, 1'h1}, '{K_DP, 16'h1234, 16'h0000, 1'h0},
             '{K_SST, 16'h0000, 16'h0000, 1'h1}, '{K_DP, 16'h5678, 16'h0000, 1'h0},
             '{K_SST, 16'h0000, 16'h0000, 1'h1}, '{K_CP, 16'h1FFF, 16'h0000, 1'h0},
             '{K_SST, 16'h0000, 16'h0000, 1'h1}, '{K_CP, 16'h6000, 16'h0000, 1'h0},
             '{K_CP, 16'h7FFF, 16'h0000, 1'h0}, '{K_SST, 16'h0000, 16'h60FF, 1'h1},
             '{K_CP, 16'hA000, 16'h0000, 1'h0}, '{K_SST, 16'h0000, 16'hA000, 1'h1},
             '{K_CP, 16'hB004, 16'h0000, 1'h0}, '{K_DP, 16'hCAFE, 16'h0000, 1'h0},
             '{K_DP, 16'hBEEF, 16'h0000, 1'h0}, '{K_DR, 16'h0000, 16'hCAFE, 1'h1},
             '{K_DR, 16'h0000, 16'hBEEF, 1'h1}, '{K_CP, 16'hB000, 16'h0000, 1'h0},
             '{K_CP, 16'h0000, 16'h0000, 1'h0}, '{K_SST, 16'h0000, 16'h0000, 1'h1}};
    repeat (5) @(negedge clock);
    sys_rst = 1'h0;
    check(32'({proc_sync, sw_wr_ack, proc_error, proc_rdata}), 32'h0);
    repeat (4) @(negedge clock);
    foreach (rows[i]) begin
      op(rows[i].kind, mk(rows[i].d));
      if (rows[i].chk) check(32'(rd), 32'(mk(rows[i].e)));
    end
    // Stored entry out to the switch side, a repeat read shows it again
    sw_read();
    sw_read();
    wd = 32'h56781234;
    e23 = {wd[22:14] & wd[31:23], wd[13:0]};
    check(32'({sw_rd_par, sw_rd_data}), 32'({~^{18'h2D3C5, e23}, e23}));
    // Switch write, then two data reads
    wd = 32'h9A5C3E71;
    sw_write(1'h0);
    check(32'(ack), 32'h1);
    op(K_DR, mk(16'h0000));
    check(32'(rd), 32'(mk(wd[15:0])));
    op(K_DR, mk(16'h0000));
    check(32'(rd), 32'(mk(wd[31:16])));
    sw_write(1'h1);
    check(32'({ack, proc_error}), 32'h1);
    // Flags read shows the switch error, then clears it
    op(K_CP, mk(16'h4000));
    op(K_SST, mk(16'h0000));
    check(32'(rd), 32'(mk(16'h400A)));
    check(32'(proc_error), 32'h0);
    // Bad processor parity blocks the entry
    op(K_DP, mk(16'h0F0F) ^ 18'h10000);
    op(K_DP, mk(16'h0F0F) ^ 18'h20000);
    check(32'(proc_error), 32'h1);
    op(K_SST, mk(16'h0000));
    check(32'(rd), 32'(mk(16'h4009)));
    check(32'(proc_error), 32'h0);
    sw_read();
    check(32'({sw_rd_par, sw_rd_data}), 32'({~^{18'h2D3C5, e23}, e23}));
    // Deep loop through both buffers
    op(K_CP, mk(16'hA000));
    op(K_CP, mk(16'hB002));
    op(K_DP, mk(16'h4321));
    op(K_DP, mk(16'h8765));
    op(K_DR, mk(16'h0000));
    check(32'(rd), 32'(mk(16'h4321)));
    op(K_DR, mk(16'h0000));
    check(32'(rd), 32'(mk(16'h8765)));
    // Short loop on the switch side: written word comes straight back
    wd = 32'h13579BDF;
    sw_write(1'h0);
    sw_read();
    e23 = {wd[22:14] & wd[31:23], wd[13:0]};
    check(32'({ack, sw_rd_par, sw_rd_data}), 32'({1'h1, ~^{18'h2D3C5, e23}, e23}));
    // Deep loop from the switch side through both buffers
    op(K_CP, mk(16'hB001));
    wd = 32'h0F1E2D3C;
    sw_write(1'h0);
    wd = 32'h7BADC0DE;
    sw_write(1'h0);
    check(32'(ack), 32'h1);
    sw_read();
    sw_read();
    e23 = {wd[22:14] & wd[31:23], wd[13:0]};
    check(32'({sw_rd_par, sw_rd_data}), 32'({~^{18'h2D3C5, e23}, e23}));
    complete_run();
  end
endmodule : dual_fifo_processor_buffer_bench
